// file: hifi_cmd_pkg.sv
package hifi_cmd_pkg;

   // Instruction codes seen on the shared remote-control bus.
   localparam int CODE_W = 6;
   localparam logic [5:0] CMD_MANUAL_TUNE = 6'h10;
   localparam logic [5:0] CMD_STATION_FIRST = 6'h11;
   localparam logic [5:0] CMD_STATION_LAST = 6'h17;
   localparam logic [5:0] CMD_SRC_TUNER = 6'h18;
   localparam logic [5:0] CMD_SRC_SECOND = 6'h19;
   localparam logic [5:0] CMD_SRC_THIRD = 6'h1a;
   localparam logic [5:0] CMD_SRC_FOURTH = 6'h1b;
   localparam logic [5:0] CMD_SWITCH_ON = 6'h1c;
   localparam logic [5:0] CMD_NORMAL = 6'h1d;
   localparam logic [5:0] CMD_MONO_STEREO = 6'h1e;
   localparam logic [5:0] CMD_TUNER_TOGGLE = 6'h1f;
   localparam logic [5:0] CMD_ARM_DOWN = 6'h20;
   localparam logic [5:0] CMD_ARM_FLIP = 6'h21;
   localparam logic [5:0] CMD_ARM_LIFT = 6'h22;
   localparam logic [5:0] CMD_PLAYER_OFF = 6'h23;
   localparam logic [5:0] CMD_WIND = 6'h28;
   localparam logic [5:0] CMD_REWIND = 6'h29;
   localparam logic [5:0] CMD_PLAY = 6'h2a;
   localparam logic [5:0] CMD_BRAKE = 6'h2b;
   localparam logic [5:0] CMD_STOP = 6'h2c;
   localparam logic [5:0] CMD_STANDBY = 6'h2d;
   localparam int GROUP_FLAG_BIT = 3;
   localparam logic [3:0] SRC_GROUP = 4'h6;

   // Source holding register, bit 0 first line, bit 1 second line, bit 2 third pin.
   localparam logic [2:0] SRC_SEL_TUNER = 3'h1;
   localparam logic [2:0] SRC_SEL_SECOND = 3'h2;
   localparam logic [2:0] SRC_SEL_THIRD = 3'h4;
   localparam logic [2:0] SRC_SEL_NONE = 3'h0;
   localparam logic [2:0] STATION_PREFERRED = 3'h1;

   // Register map, byte addresses on the APB.
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_CMD = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_LAST = 12'h00c;
   localparam logic CTRL_REMOTE_EN_RESET = 1'b1;
   localparam int CTRL_REMOTE_EN_BIT = 0;

   // Status register field positions.
   localparam int ST_STANDBY = 0;
   localparam int ST_AMP_ON = 1;
   localparam int ST_TUNER_ON = 2;
   localparam int ST_STEREO = 3;
   localparam int ST_MANUAL = 4;
   localparam int ST_ARM_DOWN = 5;
   localparam int ST_RECORDER_ON = 6;
   localparam int ST_WIND = 7;
   localparam int ST_REWIND = 8;
   localparam int ST_PLAY = 9;
   localparam int ST_BRAKE = 10;
   localparam int ST_SOURCE_LSB = 12;
   localparam int ST_STATION_LSB = 16;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// file: hifi_remote_command_decoder.sv
// Overview of operation
// R1 - Amplifier decoder answers only four codes, all having group_flag high.
// R2 - Three codes raise exactly one source output; the fourth drops all three.
// R3 - Source combination is loaded into a holding register on program_change_pulse.
// R4 - Source load strobe is group_flag combined with program_change_pulse.
// R5 - group_flag high means source switching, low means station selection.
// R6 - Source or station instruction switches the amplifier on.
// R7 - Switch-on instruction selects tuner source, programme 1 and stereo.
// R8 - Changing amplifier source to another source switches tuner power on.
// R9 - Codes 17 to 23 select stations; code 16 starts manual tuning.
// R10 - Station selection during standby switches tuner and amplifier on.
// R11 - Group-low one-of-ten decode covers stations 1-7, manual, auxiliary, tuner; the code has no group-low auxiliary or tuner decode.
// R12 - Tuner-source instruction is also a tuner power-on command.
// R13 - Mono/stereo toggle, forced stereo on wake from standby and normal instruction.
// R14 - Tuner toggle resets off; turn-on only when standby_flag is set.
// R15 - Player keeps arm down or lifted; code 33 flips the stored position.
// R16 - Wind, rewind and playback are exclusive latched states.
// R17 - Brake instruction toggles its own brake state.
// R18 - Stop clears all transport states and switches recorder off.
// R19 - Wind, rewind and playback also switch recorder power on.
// R20 - Reset forces every state flip-flop to its preferred value.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module hifi_remote_command_decoder (
   input wire logic core_clk, // System clock, 25 MHz.
   input wire logic reset, // Synchronous reset, active high.
   input wire logic [hifi_cmd_pkg::CODE_W-1:0] instr_code, // Parallel instruction bits.
   input wire logic program_change_pulse, // One-cycle pulse at each new instruction.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [hifi_cmd_pkg::ADDR_W-1:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   output logic first_source_line, // Amplifier source line one, tuner.
   output logic second_source_line, // Amplifier source line two.
   output logic third_route_pin, // Amplifier source line three.
   output logic amp_power, // Amplifier switched on.
   output logic tuner_power, // Tuner switched on.
   output logic stereo, // High for stereo, low for mono.
   output logic [2:0] station, // Selected tuner station 1 to 7.
   output logic manual_tuning, // Manual tuning active.
   output logic standby_flag, // Low while the system is in standby.
   output logic arm_down, // Record player arm down.
   output logic recorder_power, // Cassette recorder switched on.
   output logic wind, // Cassette fast wind.
   output logic rewind, // Cassette rewind.
   output logic playback, // Cassette playback.
   output logic brake // Cassette brake engaged.
);
   import hifi_cmd_pkg::*;

   function automatic logic is_source(input logic [5:0] code);
      is_source = (code[5:2] == SRC_GROUP);
   endfunction

   function automatic logic [2:0] src_decode(input logic [5:0] code);
      unique case (code[1:0])
         2'h0: src_decode = SRC_SEL_TUNER;
         2'h1: src_decode = SRC_SEL_SECOND;
         2'h2: src_decode = SRC_SEL_THIRD;
         2'h3: src_decode = SRC_SEL_NONE;
      endcase
   endfunction

   function automatic logic is_station(input logic [5:0] code);
      is_station = (code >= CMD_STATION_FIRST) && (code <= CMD_STATION_LAST);
   endfunction

   logic remote_en_ff;
   logic [5:0] last_code_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [2:0] source_ff;
   logic amp_on_ff;
   logic standby_ff;
   logic tuner_on_ff;
   logic stereo_ff;
   logic [2:0] station_ff;
   logic manual_ff;
   logic arm_down_ff;
   logic recorder_on_ff;
   logic wind_ff;
   logic rewind_ff;
   logic play_ff;
   logic brake_ff;

   logic apb_setup_done;
   logic apb_write;
   logic addr_mapped;
   logic sw_cmd;
   logic cmd_valid;
   logic [5:0] cmd_code;
   logic group_flag;
   logic src_load;
   logic station_hit;
   logic wake_hit;
   logic [31:0] nxt_prdata;

   // APB access is answered one cycle after the access phase starts.
   assign apb_setup_done = psel && penable && !pready_ff;
   assign apb_write = psel && penable && pready_ff && pwrite;
   assign addr_mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) ||
                        (paddr == REG_STATUS) || (paddr == REG_LAST);
   assign sw_cmd = apb_write && (paddr == REG_CMD);

   // A remote instruction wins over a software instruction in the same cycle.
   always_comb begin
      cmd_valid = 1'b0;
      cmd_code = instr_code;
      if (program_change_pulse && remote_en_ff) begin
         cmd_valid = 1'b1;
      end else if (sw_cmd) begin
         cmd_valid = 1'b1;
         cmd_code = pwdata[5:0];
      end
   end

   assign group_flag = cmd_code[GROUP_FLAG_BIT]; // see R5
   assign src_load = cmd_valid && group_flag && is_source(cmd_code); // see R1, see R4
   assign station_hit = cmd_valid && !group_flag && is_station(cmd_code); // see R9, see R11
   assign wake_hit = (src_load || station_hit) && !standby_ff;

   always_comb begin
      nxt_prdata = WORD_ZERO;
      unique case (paddr)
         REG_CTRL: nxt_prdata[CTRL_REMOTE_EN_BIT] = remote_en_ff;
         REG_LAST: nxt_prdata[5:0] = last_code_ff;
         REG_STATUS: begin
            nxt_prdata[ST_STANDBY] = standby_ff;
            nxt_prdata[ST_AMP_ON] = amp_on_ff;
            nxt_prdata[ST_TUNER_ON] = tuner_on_ff;
            nxt_prdata[ST_STEREO] = stereo_ff;
            nxt_prdata[ST_MANUAL] = manual_ff;
            nxt_prdata[ST_ARM_DOWN] = arm_down_ff;
            nxt_prdata[ST_RECORDER_ON] = recorder_on_ff;
            nxt_prdata[ST_WIND] = wind_ff;
            nxt_prdata[ST_REWIND] = rewind_ff;
            nxt_prdata[ST_PLAY] = play_ff;
            nxt_prdata[ST_BRAKE] = brake_ff;
            nxt_prdata[ST_SOURCE_LSB +: 3] = source_ff;
            nxt_prdata[ST_STATION_LSB +: 3] = station_ff;
         end
         default: nxt_prdata = WORD_ZERO;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= WORD_ZERO;
      end else begin
         pready_ff <= apb_setup_done;
         pslverr_ff <= apb_setup_done && !addr_mapped;
         if (apb_setup_done && !pwrite) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         remote_en_ff <= CTRL_REMOTE_EN_RESET;
      end else if (apb_write && (paddr == REG_CTRL)) begin
         remote_en_ff <= pwdata[CTRL_REMOTE_EN_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         last_code_ff <= CMD_SWITCH_ON;
      end else if (cmd_valid) begin
         last_code_ff <= cmd_code;
      end
   end

   // Source holding register.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         source_ff <= SRC_SEL_TUNER; // see R20
      end else if (cmd_valid && (cmd_code == CMD_SWITCH_ON)) begin
         source_ff <= SRC_SEL_TUNER; // see R7
      end else if (src_load) begin
         source_ff <= src_decode(cmd_code); // see R2, see R3
      end
   end

   // Standby flag and amplifier power.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         standby_ff <= 1'b0;
         amp_on_ff <= 1'b0;
      end else if (cmd_valid && (cmd_code == CMD_STANDBY)) begin
         standby_ff <= 1'b0;
         amp_on_ff <= 1'b0;
      end else if (src_load || station_hit || (cmd_valid && (cmd_code == CMD_SWITCH_ON))) begin
         standby_ff <= 1'b1; // see R14
         amp_on_ff <= 1'b1; // see R6, see R10
      end
   end

   // Tuner power, the second alternating flip-flop.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tuner_on_ff <= 1'b0; // see R14, see R20
      end else if (cmd_valid && (cmd_code == CMD_STANDBY)) begin
         tuner_on_ff <= 1'b0;
      end else if (cmd_valid && (cmd_code == CMD_SWITCH_ON)) begin
         tuner_on_ff <= 1'b1;
      end else if (cmd_valid && (cmd_code == CMD_SRC_TUNER)) begin
         tuner_on_ff <= 1'b1; // see R12
      end else if (src_load && (src_decode(cmd_code) != source_ff)) begin
         tuner_on_ff <= 1'b1; // see R8
      end else if (station_hit && !standby_ff) begin
         tuner_on_ff <= 1'b1; // see R10
      end else if (cmd_valid && (cmd_code == CMD_TUNER_TOGGLE)) begin
         tuner_on_ff <= !tuner_on_ff && standby_ff; // see R14
      end
   end

   // Mono/stereo, the first alternating flip-flop.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stereo_ff <= 1'b1; // see R20
      end else if (wake_hit) begin
         stereo_ff <= 1'b1; // see R13
      end else if (cmd_valid && ((cmd_code == CMD_NORMAL) || (cmd_code == CMD_SWITCH_ON))) begin
         stereo_ff <= 1'b1; // see R7, see R13
      end else if (cmd_valid && (cmd_code == CMD_MONO_STEREO)) begin
         stereo_ff <= !stereo_ff; // see R13
      end
   end

   // Station memory and manual tuning.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         station_ff <= STATION_PREFERRED;
         manual_ff <= 1'b0;
      end else if (cmd_valid && (cmd_code == CMD_SWITCH_ON)) begin
         station_ff <= STATION_PREFERRED; // see R7
         manual_ff <= 1'b0;
      end else if (station_hit) begin
         station_ff <= cmd_code[2:0]; // see R9
         manual_ff <= 1'b0;
      end else if (cmd_valid && (cmd_code == CMD_MANUAL_TUNE)) begin
         manual_ff <= 1'b1; // see R9, see R11
      end
   end

   // Record player arm.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         arm_down_ff <= 1'b0;
      end else if (cmd_valid) begin
         unique case (cmd_code)
            CMD_ARM_DOWN: arm_down_ff <= 1'b1; // see R15
            CMD_ARM_LIFT: arm_down_ff <= 1'b0; // see R15
            CMD_ARM_FLIP: arm_down_ff <= !arm_down_ff; // see R15
            CMD_PLAYER_OFF: arm_down_ff <= 1'b0; // see R15
            default: arm_down_ff <= arm_down_ff;
         endcase
      end
   end

   // Cassette transport.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wind_ff <= 1'b0;
         rewind_ff <= 1'b0;
         play_ff <= 1'b0;
         recorder_on_ff <= 1'b0;
      end else if (cmd_valid) begin
         unique case (cmd_code)
            CMD_WIND, CMD_REWIND, CMD_PLAY: begin
               wind_ff <= (cmd_code == CMD_WIND); // see R16
               rewind_ff <= (cmd_code == CMD_REWIND); // see R16
               play_ff <= (cmd_code == CMD_PLAY); // see R16
               recorder_on_ff <= 1'b1; // see R19
            end
            CMD_STOP: begin
               wind_ff <= 1'b0; // see R18
               rewind_ff <= 1'b0;
               play_ff <= 1'b0;
               recorder_on_ff <= 1'b0; // see R18
            end
            default: recorder_on_ff <= recorder_on_ff;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         brake_ff <= 1'b0;
      end else if (cmd_valid && (cmd_code == CMD_STOP)) begin
         brake_ff <= 1'b0; // see R18
      end else if (cmd_valid && (cmd_code == CMD_BRAKE)) begin
         brake_ff <= !brake_ff; // see R17
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign first_source_line = source_ff[0];
   assign second_source_line = source_ff[1];
   assign third_route_pin = source_ff[2];
   assign amp_power = amp_on_ff;
   assign tuner_power = tuner_on_ff;
   assign stereo = stereo_ff;
   assign station = station_ff;
   assign manual_tuning = manual_ff;
   assign standby_flag = standby_ff;
   assign arm_down = arm_down_ff;
   assign recorder_power = recorder_on_ff;
   assign wind = wind_ff;
   assign rewind = rewind_ff;
   assign playback = play_ff;
   assign brake = brake_ff;

   AST_SRC_ONE_LINE: assert property ( // see R2
      @(posedge core_clk) disable iff (reset)
      $onehot0({third_route_pin, second_source_line, first_source_line}))
      else $error("more than one source line high");

   AST_SRC_FOURTH: assert property ( // see R2
      @(posedge core_clk) disable iff (reset)
      (src_load && (cmd_code == CMD_SRC_FOURTH))
      |=> !first_source_line && !second_source_line && !third_route_pin)
      else $error("fourth source code left a source line high");

   AST_SRC_SECOND: assert property ( // see R3
      @(posedge core_clk) disable iff (reset)
      (src_load && (cmd_code == CMD_SRC_SECOND))
      |=> second_source_line && !first_source_line && !third_route_pin)
      else $error("second source code not loaded");

   AST_SRC_LOW_GROUP: assert property ( // see R4
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && !cmd_code[GROUP_FLAG_BIT]) |=> $stable(source_ff))
      else $error("group-low instruction changed the source");

   AST_AMP_ON: assert property ( // see R6
      @(posedge core_clk) disable iff (reset)
      (src_load || station_hit) |=> amp_power && standby_flag)
      else $error("amplifier not switched on by selection");

   AST_PREFERRED: assert property ( // see R7
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && (cmd_code == CMD_SWITCH_ON))
      |=> first_source_line && (station == STATION_PREFERRED) && stereo)
      else $error("switch-on did not reach preferred state");

   AST_TUNER_ON_CHANGE: assert property ( // see R8
      @(posedge core_clk) disable iff (reset)
      (src_load && (src_decode(cmd_code) != source_ff)) |=> tuner_power)
      else $error("source change left tuner off");

   AST_STATION: assert property ( // see R9
      @(posedge core_clk) disable iff (reset)
      station_hit |=> (station == $past(cmd_code[2:0])) && !manual_tuning)
      else $error("station number not stored");

   AST_WAKE: assert property ( // see R10
      @(posedge core_clk) disable iff (reset)
      (station_hit && !standby_flag) |=> tuner_power && amp_power && stereo)
      else $error("station during standby did not wake system");

   AST_TOGGLE_GATED: assert property ( // see R14
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && (cmd_code == CMD_TUNER_TOGGLE) && !tuner_power && !standby_flag)
      |=> !tuner_power)
      else $error("tuner turned on without standby flag");

   AST_ARM_FLIP: assert property ( // see R15
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && (cmd_code == CMD_ARM_FLIP)) |=> (arm_down != $past(arm_down)))
      else $error("arm flip did not change position");

   AST_TRANSPORT_EXCL: assert property ( // see R16
      @(posedge core_clk) disable iff (reset)
      $onehot0({wind, rewind, playback}))
      else $error("two transport states latched");

   AST_BRAKE: assert property ( // see R17
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && (cmd_code == CMD_BRAKE)) |=> (brake != $past(brake)))
      else $error("brake did not toggle");

   AST_STOP: assert property ( // see R18
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && (cmd_code == CMD_STOP))
      |=> !wind && !rewind && !playback && !recorder_power && !brake)
      else $error("stop left the recorder running");

   AST_PLAY_POWER: assert property ( // see R19
      @(posedge core_clk) disable iff (reset)
      (cmd_valid && (cmd_code == CMD_PLAY)) |=> playback && recorder_power)
      else $error("playback did not power the recorder");

   AST_RESET_STATE: assert property ( // see R20
      @(posedge core_clk)
      reset |=> first_source_line && stereo && !tuner_power && !amp_power && !standby_flag)
      else $error("reset did not force preferred state");

endmodule

// file: remote_rx_model.sv
`timescale 1ns/10ps
module remote_rx_model (
   input wire logic core_clk, // System clock.
   output logic [hifi_cmd_pkg::CODE_W-1:0] instr_code, // Parallel instruction bits.
   output logic program_change_pulse // One pulse per new instruction.
);
   import hifi_cmd_pkg::*;

   initial begin
      instr_code = 6'h00;
      program_change_pulse = 1'b0;
   end

   // Sends one code, or two on consecutive edges. After the last pulse the code
   // lines carry the inverse of the last code, because they are no longer held.
   task automatic send(input logic [5:0] first, input logic [5:0] second, input bit two);
      @(posedge core_clk);
      instr_code <= first;
      program_change_pulse <= 1'b1;
      if (two) begin
         @(posedge core_clk);
         instr_code <= second;
      end
      @(posedge core_clk);
      program_change_pulse <= 1'b0;
      instr_code <= ~(two ? second : first);
   endtask
endmodule

// file: tb_hifi_remote_command_decoder.sv
`timescale 1ns/10ps
module tb_hifi_remote_command_decoder;
   import hifi_cmd_pkg::*;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] instr_code;
   logic program_change_pulse, first_source_line, second_source_line, third_route_pin;
   logic amp_power, tuner_power, stereo, manual_tuning, standby_flag, arm_down;
   logic recorder_power, wind, rewind, playback, brake;
   logic [2:0] station;
   int mismatches = 0;
   int tests_run = 0;
   // Arm sequence, first code in the low six bits; expected arm state per step.
   localparam logic [35:0] ARM_C = {6'h22, 6'h20, 6'h23, 6'h21, 6'h21, 6'h20};
   localparam logic [5:0] ARM_E = 6'h15;

   remote_rx_model rx (.core_clk(core_clk), .instr_code(instr_code),
      .program_change_pulse(program_change_pulse));

   hifi_remote_command_decoder uut (.core_clk(core_clk), .reset(reset),
      .instr_code(instr_code), .program_change_pulse(program_change_pulse),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_source_line(first_source_line), .second_source_line(second_source_line),
      .third_route_pin(third_route_pin), .amp_power(amp_power), .tuner_power(tuner_power),
      .stereo(stereo), .station(station), .manual_tuning(manual_tuning),
      .standby_flag(standby_flag), .arm_down(arm_down), .recorder_power(recorder_power),
      .wind(wind), .rewind(rewind), .playback(playback), .brake(brake));

   always #20 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic cmd(input logic [5:0] c);
      rx.send(c, 6'h00, 1'b0);
      #1;
   endtask

   // One APB transfer; read data and error are taken at the edge that sees pready.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   initial begin
      #(40 * 5000);
      mismatches++;
      give_verdict();
   end

   initial begin
      core_clk = 1'b0;
      reset = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      check({third_route_pin, second_source_line, first_source_line}, 3'h1);
      check({amp_power, tuner_power, stereo, station}, 6'h09);
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check(rd, 32'h0001_1008);
      apb(1'b0, REG_LAST, 32'h0000_0000);
      check(rd, 32'h0000_001c);
      apb(1'b0, 12'h010, 32'h0000_0000);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      cmd(CMD_MONO_STEREO);
      check(stereo, 1'b0);
      cmd(CMD_STATION_FIRST + 6'h02);
      check({amp_power, tuner_power, standby_flag, station}, 6'h3b);
      check(stereo, 1'b1);
      cmd(CMD_MANUAL_TUNE);
      check(manual_tuning, 1'b1);
      cmd(CMD_TUNER_TOGGLE);
      check(tuner_power, 1'b0);
      for (int i = 0; i < 4; i++) begin
         if (i > 0) cmd(CMD_TUNER_TOGGLE);
         cmd(CMD_SRC_TUNER + 6'(i));
         check({third_route_pin, second_source_line, first_source_line},
            (i < 3) ? (SRC_SEL_TUNER << i) : SRC_SEL_NONE);
         check({amp_power, tuner_power}, 2'h3);
      end
      cmd(CMD_STATION_LAST);
      check({third_route_pin, second_source_line, first_source_line, station}, 6'h07);
      cmd(CMD_STANDBY);
      cmd(CMD_TUNER_TOGGLE);
      check({standby_flag, amp_power, tuner_power}, 3'h0);
      cmd(CMD_MONO_STEREO);
      cmd(CMD_SRC_SECOND);
      check({amp_power, stereo, second_source_line}, 3'h7);
      cmd(CMD_MONO_STEREO);
      cmd(CMD_SWITCH_ON);
      check({first_source_line, stereo, station}, 5'h19);
      cmd(CMD_MONO_STEREO);
      cmd(CMD_NORMAL);
      check(stereo, 1'b1);
      check({third_route_pin, second_source_line, first_source_line}, 3'h1);
      for (int i = 0; i < 6; i++) begin
         cmd(ARM_C[6*i +: 6]);
         check(arm_down, ARM_E[i]);
      end
      rx.send(CMD_WIND, CMD_REWIND, 1'b1);
      #1;
      check({wind, rewind, playback, recorder_power}, 4'h5);
      for (int i = 0; i < 3; i++) begin
         cmd(CMD_WIND + 6'(i));
         check({wind, rewind, playback, recorder_power}, {3'h4 >> i, 1'b1});
      end
      for (int i = 0; i < 3; i++) begin
         cmd(CMD_BRAKE);
         check(brake, (i % 2 == 0) ? 1'b1 : 1'b0);
      end
      cmd(CMD_STOP);
      check({wind, rewind, playback, recorder_power, brake}, 5'h00);
      apb(1'b1, REG_CTRL, 32'h0000_0000);
      cmd(CMD_PLAY);
      check(playback, 1'b0);
      apb(1'b1, REG_CMD, {26'h000_0000, CMD_PLAY});
      check({playback, recorder_power}, 2'h3);
      apb(1'b1, REG_CTRL, 32'h0000_0001);
      give_verdict();
   end
endmodule
